// ### hw/lpm_ctrl.sv
// Operation
// - Standby instruction in active mode enters standby.
// - Standby keeps both oscillators, halts CPU clocks, retains state.
// - Interrupts, timers, serial keep running in standby.
// - Reset leaves standby; interrupt resumes at next instruction.
// - After standby wake, service interrupt only when enable is set.
// - Stop instruction in active with watch select 0 enters stop.
// - Stop halts main oscillator; subclock follows subclock-stop bit.
// - Stop holds CPU, timers, serial, tone, comparator in reset.
// - Stop puts output pins in high impedance.
// - Stop leaves only on reset or stop-cancel.
// - After stop, RAM kept; CPU working registers may be undefined.
// - Stop instruction in active with watch select 1 enters watch.
// - Without direct transfer, stop/standby in subactive enters watch.
// - Watch: main osc off, subclock on, timer A runs, others stop.
// - Watch: externally clocked serial shifts but raises no interrupt.
// - Watch exits on reset, timer A or EXTERNAL_INTERRUPT_ZERO; low-speed picks target.
// - Timer A wake settles once; EXTERNAL_INTERRUPT_ZERO adds one to two frames.
// - Low-speed wake enters subactive: main osc off, tone reset.
// - Direct transfer: stop/standby in subactive goes to active.
// - Stop-cancel honoured only in stop mode.
// - RAM-valid reads 0 after reset exit, 1 after stop-cancel exit.
// - Enable clear with unmasked pending request makes instruction NOP.
// - Direct transfer chosen by low-speed 0, direct flag 1 in subactive.
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl #(
  parameter int SETTLE_CNT = lpm_pkg::SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [lpm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [lpm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [lpm_pkg::DATA_W-1:0] regRdData,
  input wire logic standbyInstruction,
  input wire logic stopInstruction,
  input wire logic globalInterruptEnable,
  input wire logic irqPending,
  input wire logic timerAReq,
  input wire logic externalInterruptZero,
  input wire logic frameStrobe,
  input wire logic stopCancelInput,
  output logic [lpm_pkg::MODE_W-1:0] modeState,
  output logic mainOscEn,
  output logic subOscEn,
  output logic cpuClkEn,
  output logic timerARun,
  output logic timerBdRun,
  output logic serialRun,
  output logic serialExtShiftEn,
  output logic serialIrqEn,
  output logic toneRun,
  output logic toneRst,
  output logic compRun,
  output logic periphRst,
  output logic outputHiZ,
  output logic instrNop,
  output logic wakeResume,
  output logic intServiceReq,
  output logic restartPulse,
  output logic ramValidFlag
);
  import lpm_pkg::*;

  lpm_mode_t modeFf;
  lpm_mode_t nxt_modeFf;
  logic [DATA_W-1:0] ctrlFf;
  logic [GATE_W-1:0] gateFf;
  logic [31:0] settleCntFf;
  logic [1:0] frameCntFf;
  logic [1:0] frameTgtFf;
  logic ramValidFf;
  logic nopFf;
  logic resumeFf;
  logic serviceFf;
  logic restartFf;
  logic [DATA_W-1:0] rdDataFf;
  logic instrReq;
  logic instrNopNow;
  logic settleDone;
  logic frameDone;
  logic directSel;

  // Per-mode gating of clocks and peripherals
  function automatic logic [GATE_W-1:0] gateOf(input lpm_mode_t m);
    logic [GATE_W-1:0] g;
    g = '0;
    case (m)
      LPM_ACTIVE: begin
        g = '1;
        g[G_TONERST] = 1'b0;
        g[G_PRST] = 1'b0;
        g[G_HIZ] = 1'b0;
      end
      LPM_STANDBY: begin
        // Oscillators and peripherals live; only the CPU clock and the comparator stop
        g = '1;
        g[G_CPU] = 1'b0;
        g[G_COMP] = 1'b0;
        g[G_TONERST] = 1'b0;
        g[G_PRST] = 1'b0;
        g[G_HIZ] = 1'b0;
      end
      LPM_STOP: begin
        // Everything held in reset, pins released
        g[G_PRST] = 1'b1;
        g[G_TONERST] = 1'b1;
        g[G_HIZ] = 1'b1;
      end
      LPM_STOP_SETTLE: begin
        // Main oscillator restarts while the core stays in reset
        g[G_MAIN] = 1'b1;
        g[G_PRST] = 1'b1;
        g[G_TONERST] = 1'b1;
        g[G_HIZ] = 1'b1;
      end
      LPM_WATCH, LPM_FRAME_WAIT: begin
        g[G_SUBREQ] = 1'b1;
        g[G_TMA] = 1'b1;
        g[G_SEREXT] = 1'b1;
        g[G_TONERST] = 1'b1;
      end
      LPM_SETTLE: begin
        g[G_MAIN] = 1'b1;
        g[G_SUBREQ] = 1'b1;
        g[G_TMA] = 1'b1;
        g[G_SEREXT] = 1'b1;
        g[G_TONERST] = 1'b1;
      end
      LPM_SUBACT: begin
        // Everything but the tone generator runs on the subclock
        g = '1;
        g[G_MAIN] = 1'b0;
        g[G_TONE] = 1'b0;
        g[G_PRST] = 1'b0;
        g[G_HIZ] = 1'b0;
      end
      default: g = '0;
    endcase
    return g;
  endfunction

  // Either low-power instruction
  assign instrReq = standbyInstruction | stopInstruction;
  // Instruction cancelled when it could never be woken cleanly
  assign instrNopNow = instrReq & ~globalInterruptEnable & irqPending;
  assign settleDone = (settleCntFf >= 32'(SETTLE_CNT - 1));
  assign frameDone = frameStrobe & (frameCntFf + 2'h1 >= frameTgtFf);
  assign directSel = ~ctrlFf[BIT_LOW_SPEED] & ctrlFf[BIT_DIRECT];

  // Next mode
  always_comb begin
    nxt_modeFf = modeFf;
    case (modeFf)
      LPM_ACTIVE: begin
        if (instrReq && !instrNopNow) begin
          if (standbyInstruction) begin
            nxt_modeFf = LPM_STANDBY;
          end else if (ctrlFf[BIT_WATCH_SEL]) begin
            nxt_modeFf = LPM_WATCH;
          end else begin
            nxt_modeFf = LPM_STOP;
          end
        end
      end
      LPM_STANDBY: begin
        if (irqPending) begin
          nxt_modeFf = LPM_ACTIVE;
        end
      end
      LPM_STOP: begin
        // Only stop-cancel or reset can leave here
        if (stopCancelInput) begin
          nxt_modeFf = LPM_STOP_SETTLE;
        end
      end
      LPM_STOP_SETTLE: begin
        if (settleDone) begin
          nxt_modeFf = LPM_ACTIVE;
        end
      end
      LPM_WATCH: begin
        if (timerAReq || externalInterruptZero) begin
          if (ctrlFf[BIT_LOW_SPEED]) begin
            nxt_modeFf = LPM_SUBACT;
          end else if (timerAReq) begin
            nxt_modeFf = LPM_SETTLE;
          end else begin
            nxt_modeFf = LPM_FRAME_WAIT;
          end
        end
      end
      LPM_FRAME_WAIT: begin
        if (frameDone) begin
          nxt_modeFf = LPM_SETTLE;
        end
      end
      LPM_SETTLE: begin
        if (settleDone) begin
          nxt_modeFf = LPM_ACTIVE;
        end
      end
      LPM_SUBACT: begin
        if (instrReq && !instrNopNow) begin
          if (directSel) begin
            nxt_modeFf = LPM_FRAME_WAIT;
          end else begin
            nxt_modeFf = LPM_WATCH;
          end
        end
      end
      default: nxt_modeFf = LPM_ACTIVE;
    endcase
  end

  // Encoded mode register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      modeFf <= LPM_ACTIVE;
    end else if (clkEn) begin
      modeFf <= nxt_modeFf;
    end
  end

  // Registered gate vector follows the mode being entered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gateFf <= '0;
    end else if (clkEn) begin
      gateFf <= gateOf(nxt_modeFf);
    end
  end

  // Oscillator settle counter, restarted in every other mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settleCntFf <= '0;
    end else if (clkEn) begin
      if (modeFf == LPM_SETTLE || modeFf == LPM_STOP_SETTLE) begin
        settleCntFf <= settleCntFf + 32'h1;
      end else begin
        settleCntFf <= '0;
      end
    end
  end

  // Interrupt frame counter; EXTERNAL_INTERRUPT_ZERO waits two strobes, direct waits one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frameCntFf <= '0;
      frameTgtFf <= 2'(FRAMES_EXTERNAL_INTERRUPT_ZERO);
    end else if (clkEn) begin
      if (modeFf == LPM_FRAME_WAIT) begin
        if (frameStrobe) begin
          frameCntFf <= frameCntFf + 2'h1;
        end
      end else begin
        frameCntFf <= '0;
        if (modeFf == LPM_SUBACT) begin
          frameTgtFf <= 2'(FRAMES_DIRECT);
        end else begin
          frameTgtFf <= 2'(FRAMES_EXTERNAL_INTERRUPT_ZERO);
        end
      end
    end
  end

  // Control register; direct flag only settable in subactive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlFf <= CTRL_RESET;
    end else if (clkEn) begin
      if (regWr && regAddr == ADDR_CTRL) begin
        ctrlFf <= regWrData;
        ctrlFf[BIT_DIRECT] <= regWrData[BIT_DIRECT] &
          (modeFf == LPM_SUBACT);
      end else if (modeFf == LPM_ACTIVE) begin
        ctrlFf[BIT_DIRECT] <= 1'b0;
      end
    end
  end

  // RAM-valid: cleared by reset, set when stop-cancel brings us back
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ramValidFf <= 1'b0;
    end else if (clkEn) begin
      if (modeFf == LPM_STOP_SETTLE && settleDone) begin
        ramValidFf <= 1'b1;
      end
    end
  end

  // One-cycle event pulses toward the CPU
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nopFf <= 1'b0;
      resumeFf <= 1'b0;
      serviceFf <= 1'b0;
      restartFf <= 1'b0;
    end else if (clkEn) begin
      nopFf <= instrNopNow &&
        (modeFf == LPM_ACTIVE || modeFf == LPM_SUBACT);
      // Standby wake resumes after the standby instruction
      resumeFf <= (modeFf == LPM_STANDBY) && irqPending;
      serviceFf <= (modeFf == LPM_STANDBY) && irqPending &&
        globalInterruptEnable;
      // Stop exit restarts from address zero, registers not trusted
      restartFf <= (modeFf == LPM_STOP_SETTLE) && settleDone;
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdDataFf <= '0;
    end else if (clkEn) begin
      rdDataFf <= '0;
      if (regRd) begin
        case (regAddr)
          ADDR_CTRL: rdDataFf <= ctrlFf;
          ADDR_STATUS: begin
            rdDataFf[MODE_LSB +: MODE_W] <= MODE_W'(modeFf);
            rdDataFf[BIT_RAM_VALID] <= ramValidFf;
          end
          default: rdDataFf <= '0;
        endcase
      end
    end
  end

  // Subclock stops only in stop and stop-settle modes when asked to
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      subOscEn <= 1'b1;
    end else if (clkEn) begin
      subOscEn <= ~((nxt_modeFf == LPM_STOP ||
        nxt_modeFf == LPM_STOP_SETTLE) & ctrlFf[BIT_SUB_STOP]);
    end
  end

  // Mode copy for status pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      modeState <= '0;
    end else if (clkEn) begin
      modeState <= MODE_W'(nxt_modeFf);
    end
  end

  // Outputs straight from flops
  assign mainOscEn = gateFf[G_MAIN];
  assign cpuClkEn = gateFf[G_CPU];
  assign timerARun = gateFf[G_TMA];
  assign timerBdRun = gateFf[G_TMBD];
  assign serialRun = gateFf[G_SER];
  assign serialExtShiftEn = gateFf[G_SEREXT];
  assign serialIrqEn = gateFf[G_SERIRQ];
  assign toneRun = gateFf[G_TONE];
  assign toneRst = gateFf[G_TONERST];
  assign compRun = gateFf[G_COMP];
  assign periphRst = gateFf[G_PRST];
  assign outputHiZ = gateFf[G_HIZ];
  assign instrNop = nopFf;
  assign wakeResume = resumeFf;
  assign intServiceReq = serviceFf;
  assign restartPulse = restartFf;
  assign ramValidFlag = ramValidFf;
  assign regRdData = rdDataFf;
endmodule // lpm_ctrl
`default_nettype wire

// ### hw/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;

  // Control register fields
  localparam int BIT_WATCH_SEL = 0;
  localparam int BIT_SUB_STOP = 1;
  localparam int BIT_LOW_SPEED = 2;
  localparam int BIT_DIRECT = 3;
  localparam logic [DATA_W-1:0] CTRL_RESET = 4'h0;

  // Status register fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int BIT_RAM_VALID = 3;

  // Timing: the clock is 125 MHz
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_SETTLE_NS = 1000000;
  localparam int SETTLE_CYCLES =
    (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAMES_EXTERNAL_INTERRUPT_ZERO = 2;
  localparam int FRAMES_DIRECT = 1;

  // Gate vector bit positions
  localparam int G_MAIN = 0;
  localparam int G_CPU = 1;
  localparam int G_TMA = 2;
  localparam int G_TMBD = 3;
  localparam int G_SER = 4;
  localparam int G_SEREXT = 5;
  localparam int G_SERIRQ = 6;
  localparam int G_TONE = 7;
  localparam int G_TONERST = 8;
  localparam int G_COMP = 9;
  localparam int G_PRST = 10;
  localparam int G_HIZ = 11;
  localparam int G_SUBREQ = 12;
  localparam int GATE_W = 13;

  typedef enum logic [2:0] {
    LPM_ACTIVE,
    LPM_STANDBY,
    LPM_STOP,
    LPM_WATCH,
    LPM_SUBACT,
    LPM_FRAME_WAIT,
    LPM_SETTLE,
    LPM_STOP_SETTLE
  } lpm_mode_t;
endpackage
`default_nettype wire

// ### testbench/lpm_cancel_src.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_cancel_src #(
  parameter int HOLD = 8
) (
  input wire logic clock,
  input wire logic go,
  output logic stopCancelInput
);
  int hold_ff = 0;
  // Cancel held HOLD cycles; the controller times the settle on its own count
  always @(posedge clock) begin
    if (go) begin
      hold_ff <= HOLD;
    end else if (hold_ff != 0) begin
      hold_ff <= hold_ff - 1;
    end
  end
  assign stopCancelInput = (hold_ff != 0);
endmodule // lpm_cancel_src
`default_nettype wire

// ### testbench/lpm_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_chk
  import lpm_pkg::*;
#(
  parameter int SETTLE_CNT = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic standbyInstruction,
  input wire logic stopInstruction,
  input wire logic globalInterruptEnable,
  input wire logic irqPending,
  input wire logic timerAReq,
  input wire logic stopCancelInput,
  input wire logic [MODE_W-1:0] modeState,
  input wire logic mainOscEn,
  input wire logic subOscEn,
  input wire logic cpuClkEn,
  input wire logic timerARun,
  input wire logic timerBdRun,
  input wire logic serialRun,
  input wire logic serialIrqEn,
  input wire logic toneRst,
  input wire logic periphRst,
  input wire logic outputHiZ,
  input wire logic instrNop,
  input wire logic wakeResume,
  input wire logic intServiceReq,
  input wire logic restartPulse,
  input wire logic ramValidFlag
);
  logic nopCond;
  logic anyIns;
  int settleCnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Pending unmasked work with interrupts off turns instructions into NOPs
  assign nopCond = !globalInterruptEnable && irqPending;
  assign anyIns = stopInstruction || standbyInstruction;
  // Settle cycles; frozen while clkEn is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settleCnt_ff <= 0;
    end else if (clkEn) begin
      settleCnt_ff <= (modeState == LPM_STOP_SETTLE) ? settleCnt_ff + 1 : 0;
    end
  end
  sby_enter_a: assert property (
    modeState == LPM_ACTIVE && clkEn && standbyInstruction &&
    !stopInstruction && !nopCond |=> modeState == LPM_STANDBY)
    else $error("standby entry missed");
  stop_enter_a: assert property (
    modeState == LPM_ACTIVE && clkEn && stopInstruction &&
    !standbyInstruction && !nopCond
    |=> modeState inside {LPM_STOP, LPM_WATCH})
    else $error("stop entry missed");
  nop_a: assert property (
    (modeState == LPM_ACTIVE || modeState == LPM_SUBACT) && clkEn &&
    anyIns && nopCond |=> instrNop && $stable(modeState))
    else $error("instruction not cancelled");
  sby_gate_a: assert property (
    modeState == LPM_STANDBY |-> mainOscEn && subOscEn && !cpuClkEn &&
    timerARun && serialRun)
    else $error("standby gating wrong");
  sby_wake_a: assert property (
    modeState == LPM_STANDBY && clkEn && irqPending
    |=> modeState == LPM_ACTIVE && wakeResume &&
    intServiceReq == $past(globalInterruptEnable))
    else $error("standby wake wrong");
  stop_gate_a: assert property (
    modeState == LPM_STOP |-> !mainOscEn && !cpuClkEn && periphRst &&
    outputHiZ)
    else $error("stop gating wrong");
  stop_hold_a: assert property (
    modeState == LPM_STOP && !stopCancelInput |=> modeState == LPM_STOP)
    else $error("stop left without cause");
  idle_hold_a: assert property (
    modeState == LPM_ACTIVE && !anyIns |=> modeState == LPM_ACTIVE)
    else $error("active left without cause");
  watch_gate_a: assert property (
    modeState == LPM_WATCH |-> !mainOscEn && subOscEn && timerARun &&
    !timerBdRun && !serialIrqEn && toneRst)
    else $error("watch gating wrong");
  sub_gate_a: assert property (
    modeState == LPM_SUBACT |-> !mainOscEn && toneRst && cpuClkEn &&
    timerBdRun)
    else $error("subactive gating wrong");
  settle_len_a: assert property (
    modeState == LPM_STOP_SETTLE && clkEn
    |=> (modeState == LPM_STOP_SETTLE) == (settleCnt_ff < SETTLE_CNT))
    else $error("settle length wrong");
  restart_a: assert property (
    modeState == LPM_STOP_SETTLE && clkEn &&
    settleCnt_ff == SETTLE_CNT - 1
    |=> modeState == LPM_ACTIVE && restartPulse && ramValidFlag)
    else $error("restart after cancel wrong");
  watch_wake_a: assert property (
    modeState == LPM_WATCH && clkEn && timerAReq
    |=> modeState inside {LPM_SETTLE, LPM_SUBACT})
    else $error("watch wake wrong");
  freeze_hold_a: assert property (
    !clkEn |=> $stable(modeState))
    else $error("mode moved while frozen");
  // Main paths reached
  cover property (modeState == LPM_SUBACT);
  cover property (restartPulse);
  cover property (instrNop);
endmodule // lpm_ctrl_chk
bind lpm_ctrl lpm_ctrl_chk #(.SETTLE_CNT(SETTLE_CNT)) lpm_ctrl_chk_inst (
  .clock, .rst, .clkEn, .standbyInstruction, .stopInstruction,
  .globalInterruptEnable, .irqPending, .timerAReq, .stopCancelInput,
  .modeState, .mainOscEn, .subOscEn, .cpuClkEn, .timerARun, .timerBdRun,
  .serialRun, .serialIrqEn, .toneRst, .periphRst, .outputHiZ, .instrNop,
  .wakeResume, .intServiceReq, .restartPulse, .ramValidFlag);
`default_nettype wire

// ### testbench/lpm_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_test;
  import lpm_pkg::*;
  localparam int SETTLE = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 4'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic standby_instruction = 1'b0;
  logic stp = 1'b0;
  logic gie = 1'b0;
  logic irq = 1'b0;
  logic tmrA = 1'b0;
  logic ext0 = 1'b0;
  logic frameStrobe = 1'b0;
  logic [3:0] frameCnt = 4'h0;
  logic cancelGo = 1'b0;
  logic stopCancelInput;
  logic [MODE_W-1:0] modeState;
  logic subOscEn;
  logic outputHiZ;
  logic serialExtShiftEn;
  logic toneRun;
  logic compRun;
  logic instrNop;
  logic wakeResume;
  logic intServiceReq;
  logic restartPulse;
  logic ramValidFlag;
  int errors = 0;
  int samplesChecked = 0;
  // Clock and a free-running interrupt frame of 16 cycles
  always #4 clock = ~clock;
  always @(posedge clock) begin
    frameCnt <= frameCnt + 4'h1;
    frameStrobe <= (frameCnt == 4'hF);
  end
  lpm_ctrl #(.SETTLE_CNT(SETTLE)) lpm_ctrl_inst (
    .clock, .rst, .clkEn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .standbyInstruction(standby_instruction), .stopInstruction(stp),
    .globalInterruptEnable(gie), .irqPending(irq), .timerAReq(tmrA),
    .externalInterruptZero(ext0), .frameStrobe, .stopCancelInput,
    .modeState, .mainOscEn(), .subOscEn, .cpuClkEn(), .timerARun(),
    .timerBdRun(), .serialRun(), .serialExtShiftEn, .serialIrqEn(),
    .toneRun, .toneRst(), .compRun, .periphRst(), .outputHiZ,
    .instrNop, .wakeResume, .intServiceReq, .restartPulse,
    .ramValidFlag);
  lpm_cancel_src #(.HOLD(SETTLE)) lpm_cancel_src_inst (
    .clock, .go(cancelGo), .stopCancelInput);
  // Comparison of 4-bit results
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  // One-cycle instruction pulse; stop when s is set
  task automatic ins(input bit s);
    @(posedge clock);
    stp <= s;
    standby_instruction <= !s;
    @(posedge clock);
    stp <= 1'b0;
    standby_instruction <= 1'b0;
    #1;
  endtask
  task automatic waitMode(input logic [2:0] m);
    int i;
    // Step off the edge so the mode is settled before it is looked at
    #1;
    for (i = 0; i < 200 && modeState !== m; i++) begin
      @(posedge clock);
      #1;
    end
    chk({1'b0, modeState}, {1'b0, m});
  endtask
  task automatic cancel;
    @(posedge clock);
    cancelGo <= 1'b1;
    @(posedge clock);
    cancelGo <= 1'b0;
  endtask
  task automatic t_regs;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 4'h0);
    wr(ADDR_CTRL, 4'hF);
    rd(ADDR_CTRL, 4'h7);
    wr(ADDR_STATUS, 4'hF);
    rd(ADDR_STATUS, 4'h0);
    rd(4'hF, 4'h0);
  endtask
  // Standby wake with interrupts enabled, then again with them disabled
  task automatic t_standby;
    ins(1'b0);
    waitMode(LPM_STANDBY);
    chk({2'h0, toneRun, compRun}, 4'h2);
    cancel();
    repeat (12) @(posedge clock);
    waitMode(LPM_STANDBY);
    @(posedge clock);
    gie <= 1'b1;
    irq <= 1'b1;
    waitMode(LPM_ACTIVE);
    chk({2'h0, wakeResume, intServiceReq}, 4'h3);
    @(posedge clock);
    gie <= 1'b0;
    irq <= 1'b0;
    ins(1'b0);
    waitMode(LPM_STANDBY);
    @(posedge clock);
    irq <= 1'b1;
    waitMode(LPM_ACTIVE);
    chk({2'h0, wakeResume, intServiceReq}, 4'h2);
    @(posedge clock);
    irq <= 1'b0;
  endtask
  task automatic t_nop;
    @(posedge clock);
    irq <= 1'b1;
    ins(1'b1);
    chk({3'h0, instrNop}, 4'h1);
    waitMode(LPM_ACTIVE);
    @(posedge clock);
    irq <= 1'b0;
  endtask
  // Stop with the subclock halted, then a timer request and a cancel
  task automatic t_stop;
    wr(ADDR_CTRL, 4'h2);
    ins(1'b1);
    waitMode(LPM_STOP);
    chk({3'h0, subOscEn}, 4'h0);
    chk({3'h0, outputHiZ}, 4'h1);
    @(posedge clock);
    tmrA <= 1'b1;
    repeat (4) @(posedge clock);
    waitMode(LPM_STOP);
    @(posedge clock);
    tmrA <= 1'b0;
    cancel();
    waitMode(LPM_ACTIVE);
    chk({2'h0, restartPulse, ramValidFlag}, 4'h3);
    rd(ADDR_STATUS, 4'h8);
  endtask
  // A stop instruction while frozen must not move the mode
  task automatic t_watch;
    wr(ADDR_CTRL, 4'h1);
    @(posedge clock);
    clkEn <= 1'b0;
    ins(1'b1);
    waitMode(LPM_ACTIVE);
    @(posedge clock);
    clkEn <= 1'b1;
    ins(1'b1);
    waitMode(LPM_WATCH);
    chk({1'b0, serialExtShiftEn, toneRun, compRun}, 4'h4);
    @(posedge clock);
    ext0 <= 1'b1;
    waitMode(LPM_FRAME_WAIT);
    @(posedge clock);
    ext0 <= 1'b0;
    waitMode(LPM_ACTIVE);
  endtask
  task automatic t_sub;
    wr(ADDR_CTRL, 4'h5);
    ins(1'b1);
    @(posedge clock);
    tmrA <= 1'b1;
    waitMode(LPM_SUBACT);
    @(posedge clock);
    tmrA <= 1'b0;
    ins(1'b0);
    waitMode(LPM_WATCH);
    @(posedge clock);
    tmrA <= 1'b1;
    waitMode(LPM_SUBACT);
    @(posedge clock);
    tmrA <= 1'b0;
    wr(ADDR_CTRL, 4'h9);
    rd(ADDR_CTRL, 4'h9);
    ins(1'b1);
    waitMode(LPM_FRAME_WAIT);
    waitMode(LPM_ACTIVE);
  endtask
  task automatic t_reset;
    wr(ADDR_CTRL, 4'h0);
    ins(1'b1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_STATUS, 4'h0);
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_standby();
    t_nop();
    t_stop();
    t_watch();
    t_sub();
    t_reset();
    results();
  end
  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    #160000;
    errors++;
    results();
  end
endmodule // lpm_ctrl_test
`default_nettype wire
